// ### rtl/fss_pkg.sv
package fss_pkg;

  // ***************************************************
  // Widths
  // ***************************************************
  localparam int ADDR_W = 8;   // Register address width
  localparam int DATA_W = 32;  // Register data width
  localparam int SPD_W = 16;   // Speed and parameter width
  localparam int ACC_W = 32;   // Ramp accumulator width

  // ***************************************************
  // Register byte offsets
  // ***************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;      // Control bits
  localparam logic [7:0] OFS_DECEL_TC = 8'h04;  // Decel time constant
  localparam logic [7:0] OFS_ZERO_THR = 8'h08;  // Zero speed level
  localparam logic [7:0] OFS_DELAY = 8'h0C;     // Shut-off delay, ms
  localparam logic [7:0] OFS_FFC_AMT = 8'h10;   // Freefall lift amount
  localparam logic [7:0] OFS_STATUS = 8'h14;    // Live state
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;  // Sticky events
  localparam logic [7:0] OFS_IRQ_EN = 8'h1C;    // Event enables
  localparam logic [7:0] OFS_IRQ_CLR = 8'h20;   // Write one to clear

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int CTRL_DELAY_EN = 0;   // Shut-off delay feature on
  localparam int CTRL_TORQUE = 1;     // Torque control mode
  localparam int CTRL_LINK_DB = 2;    // Link break brakes at once
  localparam int CTRL_W = 3;
  localparam int ST_STATE_LSB = 0;    // State code, 3 bits
  localparam int ST_ALARM = 4;        // Alarm latched
  localparam int ST_WARN = 5;         // Forced-stop warning shown
  localparam int ST_STO_ERR = 6;      // Torque-off timing alarm
  localparam int ST_FFC = 7;          // Freefall lift active
  localparam int IRQ_STOP = 0;        // Stop sequence began
  localparam int IRQ_SHUT = 1;        // Base shut off reached
  localparam int IRQ_STO = 2;         // Torque-off timing alarm
  localparam int IRQ_DB = 3;          // Immediate dynamic brake
  localparam int IRQ_W = 4;

  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h1;
  localparam logic [15:0] DECEL_TC_RST = 16'h0064;
  localparam logic [15:0] ZERO_THR_RST = 16'h0032;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] FFC_RST = 16'h0000;
  localparam logic [15:0] RATED_SPEED_DEF = 16'h0BB8;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 25;       // 40 MHz ref_clk
  localparam int TICK_TIME_NS = 1000000;   // 1 ms time base
  localparam int TICK_CYC_DEF = TICK_TIME_NS / CLK_PERIOD_NS;

  // ***************************************************
  // Sequencer states, Gray along the stop path
  // ***************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,   // Base off, awaiting servo-on
    ST_RUN = 3'h1,    // Driving on host command
    ST_DECEL = 3'h3,  // Following internal ramp
    ST_HOLD = 3'h2,   // Brake interlock off, delay running
    ST_SHUT = 3'h6,   // Base shut off, dynamic brake on
    ST_DYNB = 3'h4    // Immediate dynamic brake
  } fss_state_t;

endpackage

// ### rtl/fss_ramp.sv
`timescale 1ns/10ps
// Internal model speed ramp. Each ms tick adds the rated speed to an
// accumulator; every clock while the accumulator holds a whole time
// constant, one unit of speed is taken off. The speed thus falls from
// rated to zero in the time constant without a divider.
module fss_ramp
  import fss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [SPD_W-1:0] load_speed,
  input wire logic run,
  input wire logic tick,
  input wire logic [SPD_W-1:0] time_const,
  input wire logic [SPD_W-1:0] rated,
  output logic [SPD_W-1:0] speed_r
);

  logic [ACC_W-1:0] acc_r;  // Pending decrement credit
  logic [ACC_W-1:0] tc_w;   // Time constant at accumulator width

  assign tc_w = {{(ACC_W-SPD_W){1'b0}}, time_const};

  // ***************************************************
  // Accumulator and model speed
  // ***************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
      speed_r <= '0;
    end else if (load) begin
      // Start from the measured speed so the ramp joins smoothly
      acc_r <= '0;
      speed_r <= load_speed;
    end else if (run) begin
      if (time_const == '0) begin
        // Zero time constant means stop at once
        speed_r <= '0;
      end else if (tick) begin
        acc_r <= acc_r + {{(ACC_W-SPD_W){1'b0}}, rated};
      end else if (acc_r >= tc_w && speed_r != '0) begin
        acc_r <= acc_r - tc_w;
        speed_r <= speed_r - 16'h0001;
      end
    end
  end

endmodule

// ### rtl/fss_top.sv
`timescale 1ns/10ps
// Summary of operation
// [R1]: Forced-stop input off ramps at decel constant
// [R2]: Below zero speed: base off, dynamic brake
// [R3]: Shut-off delay covers stop, alarm, link break
// [R4]: Brake interlock off, then delay, then shutoff
// [R5]: Host sets delay about 1.5x freefall limit
// [R6]: Freefall lift needs amount, slow stop, delay
// [R7]: Freefall lift moves shaft up by amount
// [R8]: Dynamic-brake alarms skip ramp, brake at once
// [R9]: Dynamic-brake alarm during ramp aborts ramp
// [R10]: Torque-off lost during ramp raises alarm
// [R11]: No ramp stop in torque control mode
// [R12]: Alarm cleared by resets unless cause remains
// [R13]: Ramp follows internal model, ignores host
// [R14]: Link break may brake at once by mode
// [R15]: Forced-stop warning shown during stop sequence
// [R16]: Link break starts ramp like forced stop
// [R17]: Shutoff held until clear, then new servo-on
module fss_top
  import fss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC_DEF,   // Clocks per ms
  parameter logic [SPD_W-1:0] RATED = RATED_SPEED_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic forced_stop_two_input,
  input wire logic safe_torque_off_input,
  input wire logic link_break,
  input wire logic alarm_req,
  input wire logic alarm_db,
  input wire logic alarm_cause_present,
  input wire logic error_reset_cmd,
  input wire logic cpu_reset_cmd,
  input wire logic servo_on_cmd,
  input wire logic [SPD_W-1:0] measured_speed,
  input wire logic [SPD_W-1:0] host_speed_cmd,
  output logic [SPD_W-1:0] speed_cmd_r,
  output logic [SPD_W-1:0] freefall_lift_r,
  output logic base_drive_r,
  output logic dynamic_brake_r,
  output logic brake_interlock_output,
  output logic forced_stop_warning,
  output logic torque_off_timing_error_alarm,
  output logic malfunction_output,
  output logic irq
);

  // ***************************************************
  // Declarations
  // ***************************************************
  fss_state_t state_r;               // Sequencer state
  fss_state_t state_nxt;             // Next sequencer state
  logic [CTRL_W-1:0] ctrl_r;         // Control bits
  logic [SPD_W-1:0] decel_tc_r;      // Decel time constant, ms
  logic [SPD_W-1:0] zero_thr_r;      // Zero speed threshold
  logic [SPD_W-1:0] delay_r;         // Shut-off delay, ms
  logic [SPD_W-1:0] ffc_amt_r;       // Freefall lift amount
  logic [IRQ_W-1:0] irq_stat_r;      // Sticky event bits
  logic [IRQ_W-1:0] irq_en_r;        // Event enables
  logic [IRQ_W-1:0] irq_evt;         // Events this cycle
  logic [31:0] tick_cnt_r;           // Ms divider
  logic tick;                        // One-cycle ms pulse
  logic [SPD_W-1:0] hold_cnt_r;      // Ms spent in hold
  logic alarm_r;                     // Alarm latched
  logic sto_err_r;                   // Torque-off timing alarm
  logic ffc_r;                       // Freefall lift selected
  logic servo_on_d_r;                // Servo-on, last cycle
  logic servo_on_rise;               // New servo-on command
  logic stop_cause;                  // Forced stop, alarm or link break
  logic low_speed;                   // At or below zero speed
  logic below_zero;                  // Strictly below zero speed
  logic hold_done;                   // Delay has elapsed
  logic clear_req;                   // Alarm clear request
  logic ramp_load;                   // Seed model speed
  logic [SPD_W-1:0] model_speed;     // Internal ramp output

  function automatic logic is_off(input fss_state_t s);
    // Base drive is off in these states
    return s == ST_IDLE || s == ST_SHUT || s == ST_DYNB;
  endfunction

  // ***************************************************
  // Time base
  // ***************************************************
  // Ms pulse from the single clock; slow logic uses it as an enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // ***************************************************
  // Stop conditions
  // ***************************************************
  // Forced stop, alarm and link break all start a stop
  assign stop_cause = !forced_stop_two_input || alarm_r ||
                      link_break;                       // [R3] [R16]
  assign low_speed = measured_speed <= zero_thr_r;
  assign below_zero = measured_speed < zero_thr_r;
  assign hold_done = hold_cnt_r >= delay_r;
  assign clear_req = error_reset_cmd || cpu_reset_cmd;
  assign servo_on_rise = servo_on_cmd && !servo_on_d_r;

  // ***************************************************
  // Sequencer next state
  // ***************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        // Only a fresh servo-on drives again
        if (servo_on_rise && !stop_cause) begin
          state_nxt = ST_RUN;                           // [R17]
        end
      end
      ST_RUN: begin
        if (alarm_db) begin
          state_nxt = ST_DYNB;                          // [R8]
        end else if (stop_cause && ctrl_r[CTRL_TORQUE]) begin
          // No ramp in torque mode
          state_nxt = ST_DYNB;                          // [R11]
        end else if (link_break && ctrl_r[CTRL_LINK_DB]) begin
          state_nxt = ST_DYNB;                          // [R14]
        end else if (stop_cause && low_speed &&
                     ctrl_r[CTRL_DELAY_EN] && ffc_amt_r != '0) begin
          // Already stopped: lift shaft during the hold
          state_nxt = ST_HOLD;                          // [R6]
        end else if (stop_cause) begin
          state_nxt = ST_DECEL;                         // [R1]
        end else if (!servo_on_cmd) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_DECEL: begin
        if (alarm_db || !safe_torque_off_input) begin
          // Abandon the ramp for immediate braking
          state_nxt = ST_DYNB;                          // [R9] [R10]
        end else if (below_zero && ctrl_r[CTRL_DELAY_EN]) begin
          state_nxt = ST_HOLD;                          // [R4]
        end else if (below_zero) begin
          state_nxt = ST_SHUT;                          // [R2]
        end
      end
      ST_HOLD: begin
        if (alarm_db) begin
          state_nxt = ST_DYNB;
        end else if (hold_done) begin
          state_nxt = ST_SHUT;                          // [R4]
        end
      end
      ST_SHUT, ST_DYNB: begin
        // Leave once nothing keeps the stop alive
        if (!alarm_r && !alarm_db && forced_stop_two_input &&
            !link_break) begin
          state_nxt = ST_IDLE;                          // [R17]
        end
      end
      default: state_nxt = ST_DYNB;  // Illegal code: brake at once
    endcase
  end

  // ***************************************************
  // Sequencer state
  // ***************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      servo_on_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      servo_on_d_r <= servo_on_cmd;
    end
  end

  // ***************************************************
  // Shut-off delay counter
  // ***************************************************
  // Counts ms only in hold; restarts on every entry
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_r <= '0;
    end else if (state_r != ST_HOLD) begin
      hold_cnt_r <= '0;
    end else if (tick && !hold_done) begin
      hold_cnt_r <= hold_cnt_r + 16'h0001;              // [R4]
    end
  end

  // ***************************************************
  // Freefall lift
  // ***************************************************
  // Chosen on the slow-stop entry to hold, kept to shutoff
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ffc_r <= 1'b0;
    end else if (state_r == ST_RUN && state_nxt == ST_HOLD && stop_cause) begin
      ffc_r <= 1'b1;                                    // [R6]
    end else if (state_r != ST_HOLD) begin
      ffc_r <= 1'b0;
    end
  end

  // ***************************************************
  // Alarm latches
  // ***************************************************
  // A new alarm wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_r <= 1'b0;
      sto_err_r <= 1'b0;
    end else begin
      if (alarm_req || alarm_db) begin
        alarm_r <= 1'b1;
      end else if (clear_req && !alarm_cause_present) begin
        alarm_r <= 1'b0;                                // [R12]
      end
      if (state_r == ST_DECEL && !safe_torque_off_input) begin
        sto_err_r <= 1'b1;                              // [R10]
      end else if (clear_req && safe_torque_off_input) begin
        sto_err_r <= 1'b0;                              // [R12]
      end
    end
  end

  // ***************************************************
  // Model speed ramp
  // ***************************************************
  assign ramp_load = state_r == ST_RUN && state_nxt == ST_DECEL;

  fss_ramp u_ramp (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(ramp_load),
    .load_speed(measured_speed),
    .run(state_r == ST_DECEL),
    .tick(tick),
    .time_const(decel_tc_r),
    .rated(RATED),
    .speed_r(model_speed)                               // [R1]
  );

  // ***************************************************
  // Drive outputs
  // ***************************************************
  // Registered so the power stage never sees decode glitches
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_cmd_r <= '0;
      freefall_lift_r <= '0;
      base_drive_r <= 1'b0;
      dynamic_brake_r <= 1'b1;
    end else begin
      base_drive_r <= !is_off(state_nxt);               // [R2]
      dynamic_brake_r <= is_off(state_nxt);             // [R2] [R8]
      if (state_nxt == ST_DECEL) begin
        speed_cmd_r <= ramp_load ? measured_speed : model_speed; // [R13]
      end else if (state_nxt == ST_RUN) begin
        speed_cmd_r <= host_speed_cmd;
      end else begin
        speed_cmd_r <= '0;
      end
      freefall_lift_r <= ffc_r ? ffc_amt_r : '0;        // [R7]
    end
  end

  // Brake released only while driving or ramping
  assign brake_interlock_output = state_r == ST_RUN ||
                                  state_r == ST_DECEL;  // [R4]
  assign forced_stop_warning = !forced_stop_two_input && !is_off(state_r) &&
                               state_r != ST_RUN;       // [R15]
  assign torque_off_timing_error_alarm = sto_err_r;
  assign malfunction_output = !(alarm_r || sto_err_r);

  // ***************************************************
  // Interrupts
  // ***************************************************
  always_comb begin
    irq_evt[IRQ_STOP] = state_r == ST_RUN && state_nxt != ST_RUN;
    irq_evt[IRQ_SHUT] = state_r != ST_SHUT && state_nxt == ST_SHUT;
    irq_evt[IRQ_STO] = state_r == ST_DECEL && !safe_torque_off_input;
    irq_evt[IRQ_DB] = state_r != ST_DYNB && state_nxt == ST_DYNB;
  end
  // Set beats clear so no event is lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
    end else if (reg_wr && reg_addr == OFS_IRQ_CLR) begin
      irq_stat_r <= (irq_stat_r & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ***************************************************
  // Register writes
  // ***************************************************
  // Settings may change at any time; the ramp reads them live
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      decel_tc_r <= DECEL_TC_RST;
      zero_thr_r <= ZERO_THR_RST;
      delay_r <= DELAY_RST;
      ffc_amt_r <= FFC_RST;
      irq_en_r <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL: ctrl_r <= reg_wdata[CTRL_W-1:0];
        OFS_DECEL_TC: decel_tc_r <= reg_wdata[SPD_W-1:0];
        OFS_ZERO_THR: zero_thr_r <= reg_wdata[SPD_W-1:0];
        OFS_DELAY: delay_r <= reg_wdata[SPD_W-1:0];
        OFS_FFC_AMT: ffc_amt_r <= reg_wdata[SPD_W-1:0];
        OFS_IRQ_EN: irq_en_r <= reg_wdata[IRQ_W-1:0];
        default: begin
          // Read-only and unmapped writes are dropped
        end
      endcase
    end
  end

  // ***************************************************
  // Register reads
  // ***************************************************
  // Data stands for one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL: reg_rdata <= DATA_W'(ctrl_r);
        OFS_DECEL_TC: reg_rdata <= DATA_W'(decel_tc_r);
        OFS_ZERO_THR: reg_rdata <= DATA_W'(zero_thr_r);
        OFS_DELAY: reg_rdata <= DATA_W'(delay_r);
        OFS_FFC_AMT: reg_rdata <= DATA_W'(ffc_amt_r);
        OFS_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[ST_STATE_LSB +: 3] <= state_r;
          reg_rdata[ST_ALARM] <= alarm_r;
          reg_rdata[ST_WARN] <= forced_stop_warning;
          reg_rdata[ST_STO_ERR] <= sto_err_r;
          reg_rdata[ST_FFC] <= ffc_r;
        end
        OFS_IRQ_STAT: reg_rdata <= DATA_W'(irq_stat_r);
        OFS_IRQ_EN: reg_rdata <= DATA_W'(irq_en_r);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// ### tb/fss_chk_sva.sv
`timescale 1ns/10ps
// ***********************************
// Port checker for the stop sequencer
// ***********************************
module fss_chk_sva
  import fss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic forced_stop_two_input,
  input wire logic safe_torque_off_input,
  input wire logic alarm_db,
  input wire logic alarm_cause_present,
  input wire logic servo_on_cmd,
  input wire logic [SPD_W-1:0] speed_cmd_r,
  input wire logic base_drive_r,
  input wire logic dynamic_brake_r,
  input wire logic brake_interlock_output,
  input wire logic forced_stop_warning,
  input wire logic malfunction_output,
  input wire logic torque_off_timing_error_alarm
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Ramp phase: interlock still released and warning shown
  sequence s_decel;
    forced_stop_warning && brake_interlock_output;
  endsequence
  // Interlock drop without the brake marks the hold phase
  sequence s_hold_entry;
    $fell(brake_interlock_output) && !dynamic_brake_r;
  endsequence
  a_ramp_no_rise:
    assert property (s_decel ##1 s_decel
      |-> speed_cmd_r <= $past(speed_cmd_r)) else $error("ramp rose");
  a_hold_base_on:
    assert property (s_hold_entry |-> base_drive_r)
      else $error("base off before delay");
  a_dynb_on_alarm:
    assert property (alarm_db && brake_interlock_output
      |=> dynamic_brake_r && !base_drive_r) else $error("no dyn brake");
  a_sto_in_ramp:
    assert property (s_decel ##0 !safe_torque_off_input
      |=> torque_off_timing_error_alarm) else $error("no sto alarm");
  a_warn_cause:
    assert property (forced_stop_warning
      |-> !forced_stop_two_input && base_drive_r) else $error("bad warn");
  a_clear_blocked:
    assert property (!malfunction_output && alarm_cause_present
      |=> !malfunction_output) else $error("alarm cleared early");
  a_start_needs_on:
    assert property ($rose(base_drive_r)
      |-> servo_on_cmd && malfunction_output) else $error("bad start");
  a_off_quiet:
    assert property (!base_drive_r |-> speed_cmd_r == '0
      && !forced_stop_warning) else $error("command while off");
endmodule

// ### tb/fss_motor_model.sv
`timescale 1ns/10ps
// ***********************************
// Shaft model: follows the command a clock late
// ***********************************
// With base drive off the shaft reads stopped at once; harsher than a
// slow coast for the zero-speed logic.
module fss_motor_model
  import fss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic base_drive_r,
  input wire logic [SPD_W-1:0] speed_cmd_r,
  output logic [SPD_W-1:0] measured_speed
);
  // Speed feedback register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      measured_speed <= '0;
    end else begin
      measured_speed <= base_drive_r ? speed_cmd_r : '0;
    end
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
// ***********************************
// Stop sequencer bench
// ***********************************
module tb_top;
  import fss_pkg::*;
  logic ref_clk, rst_n, reg_wr, reg_rd, forced_stop_two_input, irq;
  logic safe_torque_off_input, link_break, alarm_req, alarm_db;
  logic alarm_cause_present, error_reset_cmd, cpu_reset_cmd, servo_on_cmd;
  logic base_drive_r, dynamic_brake_r, brake_interlock_output;
  logic forced_stop_warning, torque_off_timing_error_alarm;
  logic malfunction_output;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [SPD_W-1:0] measured_speed, host_speed_cmd, speed_cmd_r;
  logic [SPD_W-1:0] freefall_lift_r;
  int err_total, n_tests, i;
  // Ten clocks per ms tick keeps the run short
  fss_top #(.TICK_CYCLES(10)) i_fss_top (.ref_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .forced_stop_two_input,
    .safe_torque_off_input, .link_break, .alarm_req, .alarm_db,
    .alarm_cause_present, .error_reset_cmd, .cpu_reset_cmd, .servo_on_cmd,
    .measured_speed, .host_speed_cmd, .speed_cmd_r, .freefall_lift_r,
    .base_drive_r, .dynamic_brake_r, .brake_interlock_output,
    .forced_stop_warning, .torque_off_timing_error_alarm,
    .malfunction_output, .irq);
  fss_motor_model i_fss_motor_model (.ref_clk, .rst_n, .base_drive_r,
    .speed_cmd_r, .measured_speed);
  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stands only in the cycle after the read edge
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Bounded wait on base drive (k=1) or the interlock (k=0)
  task automatic wt(input bit k, input logic v);
    for (i = 0; i < 3000; i++) begin
      @(posedge ref_clk);
      #1;
      if ((k ? base_drive_r : brake_interlock_output) === v) return;
    end
    err_total++;
    wrap_up();
  endtask
  // Servo-on drops too, so a command held through reset cannot restart
  task automatic boot;
    {rst_n, servo_on_cmd} <= 2'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic cfg;
    wr(OFS_DECEL_TC, 32'h2);
    wr(OFS_DELAY, 32'h3);
    wr(OFS_IRQ_EN, 32'hF);
  endtask
  // Servo-on needs a fresh rising edge
  task automatic run_up;
    @(posedge ref_clk);
    servo_on_cmd <= 1'b0;
    repeat (4) @(posedge ref_clk);
    servo_on_cmd <= 1'b1;
    wt(0, 1'b1);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic clr(input bit cpu);
    @(posedge ref_clk);
    {error_reset_cmd, cpu_reset_cmd} <= {!cpu, cpu};
    @(posedge ref_clk);
    {error_reset_cmd, cpu_reset_cmd} <= 2'h0;
    #1;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    {reg_wr, reg_rd, link_break, alarm_req, alarm_db, rst_n} = '0;
    {alarm_cause_present, error_reset_cmd, cpu_reset_cmd, servo_on_cmd} = '0;
    {forced_stop_two_input, safe_torque_off_input} = 2'h3;
    {reg_addr, reg_wdata, err_total, n_tests} = '0;
    host_speed_cmd = 16'h0064;
    boot();
    rdchk(OFS_CTRL, 32'h1);
    rdchk(OFS_DECEL_TC, 32'h64);
    rdchk(OFS_ZERO_THR, 32'h32);
    rdchk(OFS_DELAY, 32'h0);
    rdchk(OFS_FFC_AMT, 32'h0);
    rdchk(8'h40, 32'h0);
    cfg();
    // Ramped stop, interlock drop, delay, then shut-off
    run_up();
    forced_stop_two_input <= 1'b0;
    host_speed_cmd <= 16'h00C8;
    @(posedge ref_clk);
    #1 chk(forced_stop_warning, 1'b1);
    chk(speed_cmd_r <= 16'h0064, 1'b1);
    wt(0, 1'b0);
    chk(base_drive_r, 1'b1);
    wt(1, 1'b0);
    chk(i >= 18 && i <= 32, 1'b1);
    chk(dynamic_brake_r, 1'b1);
    chk(irq, 1'b1);
    rdchk(OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_CLR, 32'hF);
    chk(irq, 1'b0);
    forced_stop_two_input <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk(base_drive_r, 1'b0);
    // Link break at standstill lifts the shaft
    wr(OFS_FFC_AMT, 32'h7);
    host_speed_cmd <= 16'h0000;
    run_up();
    link_break <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk(freefall_lift_r, 32'h7);
    wt(1, 1'b0);
    chk(dynamic_brake_r, 1'b1);
    {link_break, host_speed_cmd} <= {1'b0, 16'h0064};
    wr(OFS_IRQ_CLR, 32'hF);
    // Torque-off lost mid-ramp, then a refused and a good clear
    run_up();
    forced_stop_two_input <= 1'b0;
    @(posedge ref_clk);
    safe_torque_off_input <= 1'b0;
    @(posedge ref_clk);
    #1 chk(torque_off_timing_error_alarm, 1'b1);
    chk({malfunction_output, dynamic_brake_r}, 2'h1);
    // A ramped-stop alarm with its cause standing: the clear is refused
    {alarm_cause_present, alarm_req} <= 2'h3;
    @(posedge ref_clk);
    alarm_req <= 1'b0;
    clr(1'b0);
    chk(malfunction_output, 1'b0);
    {alarm_cause_present, safe_torque_off_input} <= 2'h1;
    forced_stop_two_input <= 1'b1;
    clr(1'b1);
    chk(malfunction_output, 1'b1);
    rdchk(OFS_IRQ_STAT, 32'hD);
    // Immediate dynamic brake alarm while running
    boot();
    cfg();
    run_up();
    alarm_db <= 1'b1;
    @(posedge ref_clk);
    #1 chk({dynamic_brake_r, base_drive_r}, 2'h2);
    rdchk(OFS_STATUS, 32'h14);
    // Torque mode: no ramp, brake at once
    boot();
    alarm_db <= 1'b0;
    wr(OFS_CTRL, 32'h3);
    run_up();
    forced_stop_two_input <= 1'b0;
    @(posedge ref_clk);
    #1 chk({dynamic_brake_r, forced_stop_warning}, 2'h2);
    // Link break set to brake at once
    boot();
    forced_stop_two_input <= 1'b1;
    wr(OFS_CTRL, 32'h5);
    run_up();
    link_break <= 1'b1;
    @(posedge ref_clk);
    #1 chk(dynamic_brake_r, 1'b1);
    wrap_up();
  end
endmodule
bind fss_top fss_chk_sva i_chk (.ref_clk, .rst_n, .forced_stop_two_input,
  .safe_torque_off_input, .alarm_db, .alarm_cause_present, .servo_on_cmd,
  .speed_cmd_r, .base_drive_r, .dynamic_brake_r, .brake_interlock_output,
  .forced_stop_warning, .malfunction_output,
  .torque_off_timing_error_alarm);
